// [core/vec_ctrl.sv]
// ejector suction/blow-off control with apb registers and display blocks
// assumes synchronous inputs on pclk and an apb master on the same clock
//
// What this block does
// R01: halt suction when vacuum reaches switch point
// R02: resume suction when vacuum below reset point
// R03: measure leakage mbar/s from control halt
// R04: no control mode: suction always on
// R05: switch point evaluation follows control state
// R06: external blow-off follows blow input exactly
// R07: blow input wins over suction input
// R08: timed blow-off after leaving suction
// R09: blow input overrides suction in timed mode
// R10: blow time 0.01 to 9.99 seconds
// R11: zero blow time selects external blow-off
// R12: vacuum shown in selectable unit; the kPa setting shows the mbar value unconverted
// R13: factory reset keeps counters
// R14: count every suction input pulse, cleared only by presetn
// R15: count every suction valve turn-on
// R16: save counters every thousandth increment
// R17: counters shown as three-digit blocks, highest first
// R18: part number as four blocks, eleven digits
// R19: serial number as three three-digit blocks
// R20: software id shown until exit
// R21: compare in mbar, convert only for display
// R22: counters hold nine decimal digits
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "vec_defines.svh"

module vec_ctrl #(
    parameter int unsigned HSEC_CYCLES = `VEC_HSEC_NS / `VEC_CLK_NS,
    parameter int unsigned SEC_CYCLES = `VEC_SEC_NS / `VEC_CLK_NS,
    parameter logic [29:0] SERIAL_NO = 30'h0001_E240,
    parameter logic [9:0] PART_B0 = 10'h00C,
    parameter logic [9:0] PART_B1 = 10'h022,
    parameter logic [9:0] PART_B2 = 10'h038,
    parameter logic [9:0] PART_B3 = 10'h04E,
    parameter logic [9:0] SW_ID = 10'h065
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic suction_in,
    input wire logic blowoff_in,
    input wire logic [15:0] vacuum_level,
    input wire logic disp_next,
    output logic suction_valve,
    output logic blowoff_valve,
    output logic [9:0] disp_block,
    output logic [2:0] disp_point
);
    // arbitrary identity values above; not tied to any product

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [9:0] blk3(input logic [29:0] v,
                                        input logic [1:0] idx);
        logic [29:0] q;
        q = 30'h0;
        case (idx)
            2'h0: q = v / 30'h000F_4240;
            2'h1: q = (v / 30'h0000_03E8) % 30'h0000_03E8;
            default: q = v % 30'h0000_03E8;
        endcase
        return q[9:0];
    endfunction

    function automatic logic [9:0] wrap_inc(input logic [9:0] m);
        return (m == `VEC_NV_WRAP) ? 10'h000 : m + 10'h001;
    endfunction

    // ****************************************
    // registers
    // ****************************************
    logic mode_r;
    logic [1:0] unit_r;
    logic [15:0] switch_pt_r;
    logic [15:0] reset_pt_r;
    logic [9:0] blow_time_r;
    logic [9:0] leak_lim_r;
    logic [2:0] disp_item_r;
    logic [1:0] disp_idx_r;
    vec_pkg::vec_state_t state_r;
    vec_pkg::vec_state_t state_nxt;
    logic [31:0] tick_r;
    logic [9:0] hsec_r;
    logic suction_d_r;
    logic [29:0] cnt1_r;
    logic [29:0] cnt2_r;
    logic [9:0] mod1_r;
    logic [9:0] mod2_r;
    logic [29:0] nv1_r;
    logic [29:0] nv2_r;
    logic leak_run_r;
    logic [31:0] leak_tmr_r;
    logic [15:0] leak_start_r;
    logic [15:0] leak_rate_r;
    logic leak_err_r;
    logic [31:0] vac_disp_r;
    logic [9:0] disp_block_nxt;
    logic [2:0] disp_point_nxt;
    logic [31:0] rd_nxt;
    logic hit;
    logic wr_en;
    logic sel_wr;
    logic fact_rst;
    logic suck_rise;
    logic suck_enter;

    assign wr_en = psel & penable & pready & pwrite;
    assign sel_wr = wr_en & (paddr == `VEC_OFS_DISPSEL);
    assign fact_rst = wr_en & (paddr == `VEC_OFS_CTRL) & pwdata[3];
    assign suck_rise = suction_in & ~suction_d_r;
    assign suck_enter = (state_nxt == vec_pkg::VEC_SUCK) &&
                        (state_r != vec_pkg::VEC_SUCK);

    // ****************************************
    // apb slave, one cycle answer
    // ****************************************
    always_comb
    begin
        hit = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr)
            `VEC_OFS_CTRL: rd_nxt = {29'h0, unit_r, mode_r};
            `VEC_OFS_SWITCH: rd_nxt = {16'h0, switch_pt_r};
            `VEC_OFS_RESET: rd_nxt = {16'h0, reset_pt_r};
            `VEC_OFS_BLOW: rd_nxt = {22'h0, blow_time_r};
            `VEC_OFS_LEAKLIM: rd_nxt = {22'h0, leak_lim_r};
            `VEC_OFS_STATUS:
                rd_nxt = {22'h0, state_r, leak_err_r, leak_run_r,
                          blowoff_valve, suction_valve, 1'b0};
            `VEC_OFS_LEAKRATE: rd_nxt = {16'h0, leak_rate_r};
            `VEC_OFS_VACDISP: rd_nxt = vac_disp_r;
            `VEC_OFS_CNT1: rd_nxt = {2'h0, cnt1_r};
            `VEC_OFS_CNT2: rd_nxt = {2'h0, cnt2_r};
            `VEC_OFS_NV1: rd_nxt = {2'h0, nv1_r};
            `VEC_OFS_NV2: rd_nxt = {2'h0, nv2_r};
            `VEC_OFS_DISPSEL: rd_nxt = {27'h0, disp_idx_r, disp_item_r};
            `VEC_OFS_DISPOUT: rd_nxt = {19'h0, disp_point, disp_block};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel && !penable && !pwrite)
                prdata <= rd_nxt;
        end
    end

    // R13 factory reset restores config only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= `VEC_RST_MODE;
            unit_r <= `VEC_RST_UNIT;
            switch_pt_r <= `VEC_RST_SWITCH;
            reset_pt_r <= `VEC_RST_RESETPT;
            blow_time_r <= `VEC_RST_BLOW;
            leak_lim_r <= `VEC_RST_LEAK;
        end
        else if (fact_rst)
        begin
            mode_r <= `VEC_RST_MODE;
            unit_r <= `VEC_RST_UNIT;
            switch_pt_r <= `VEC_RST_SWITCH;
            reset_pt_r <= `VEC_RST_RESETPT;
            blow_time_r <= `VEC_RST_BLOW;
            leak_lim_r <= `VEC_RST_LEAK;
        end
        else if (wr_en)
        begin
            case (paddr)
                `VEC_OFS_CTRL:
                begin
                    mode_r <= pwdata[0];
                    unit_r <= pwdata[2:1];
                end
                `VEC_OFS_SWITCH: switch_pt_r <= pwdata[15:0];
                `VEC_OFS_RESET: reset_pt_r <= pwdata[15:0];
                // R10 blow time clipped to 9.99 s
                `VEC_OFS_BLOW:
                    blow_time_r <= (pwdata[9:0] > `VEC_BLOW_MAX) ?
                                   `VEC_BLOW_MAX : pwdata[9:0];
                `VEC_OFS_LEAKLIM: leak_lim_r <= pwdata[9:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // suction and blow-off sequencing
    // ****************************************
    always_comb
    begin
        state_nxt = state_r;
        // R07 blow input has priority
        if (blowoff_in)
            state_nxt = vec_pkg::VEC_EBLOW;
        else
        begin
            case (state_r)
                vec_pkg::VEC_IDLE, vec_pkg::VEC_EBLOW:
                    state_nxt = suction_in ? vec_pkg::VEC_SUCK
                                           : vec_pkg::VEC_IDLE;
                vec_pkg::VEC_SUCK, vec_pkg::VEC_HOLD:
                begin
                    // R08 R11 timed blow only with nonzero time
                    if (!suction_in)
                        state_nxt = (blow_time_r != 10'h000) ?
                                    vec_pkg::VEC_TBLOW : vec_pkg::VEC_IDLE;
                    // R04 no control keeps suction on
                    else if (!mode_r)
                        state_nxt = vec_pkg::VEC_SUCK;
                    // R01 R05 R21 halt at switch point
                    else if (state_r == vec_pkg::VEC_SUCK &&
                             vacuum_level >= switch_pt_r)
                        state_nxt = vec_pkg::VEC_HOLD;
                    // R02 resume below reset point
                    else if (state_r == vec_pkg::VEC_HOLD &&
                             vacuum_level < reset_pt_r)
                        state_nxt = vec_pkg::VEC_SUCK;
                end
                vec_pkg::VEC_TBLOW:
                    if (suction_in)
                        state_nxt = vec_pkg::VEC_SUCK;
                    else if (hsec_r == blow_time_r)
                        state_nxt = vec_pkg::VEC_IDLE;
                default: state_nxt = vec_pkg::VEC_IDLE;
            endcase
        end
    end

    // R06 R09 valves follow the sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= vec_pkg::VEC_IDLE;
            suction_valve <= 1'b0;
            blowoff_valve <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            suction_valve <= (state_nxt == vec_pkg::VEC_SUCK);
            blowoff_valve <= (state_nxt == vec_pkg::VEC_EBLOW) ||
                             (state_nxt == vec_pkg::VEC_TBLOW);
        end
    end

    // R08 R10 blow timer in hundredths of a second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_r <= 32'h0000_0000;
            hsec_r <= 10'h000;
        end
        else if (state_r != vec_pkg::VEC_TBLOW)
        begin
            tick_r <= 32'h0000_0000;
            hsec_r <= 10'h000;
        end
        else if (tick_r == HSEC_CYCLES - 1)
        begin
            tick_r <= 32'h0000_0000;
            hsec_r <= hsec_r + 10'h001;
        end
        else
            tick_r <= tick_r + 32'h0000_0001;
    end

    // ****************************************
    // counters, cleared only by presetn
    // ****************************************
    // R14 R15 R16 R22 counting and saving
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            suction_d_r <= 1'b0;
            cnt1_r <= 30'h0;
            cnt2_r <= 30'h0;
            mod1_r <= 10'h000;
            mod2_r <= 10'h000;
            nv1_r <= 30'h0;
            nv2_r <= 30'h0;
        end
        else
        begin
            suction_d_r <= suction_in;
            if (suck_rise)
            begin
                cnt1_r <= cnt1_r + 30'h1;
                mod1_r <= wrap_inc(mod1_r);
                if (mod1_r == `VEC_NV_WRAP)
                    nv1_r <= cnt1_r + 30'h1;
            end
            if (suck_enter)
            begin
                cnt2_r <= cnt2_r + 30'h1;
                mod2_r <= wrap_inc(mod2_r);
                if (mod2_r == `VEC_NV_WRAP)
                    nv2_r <= cnt2_r + 30'h1;
            end
        end
    end

    // ****************************************
    // leakage over one second after a halt
    // ****************************************
    // R03 leak rate from the halt instant
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            leak_run_r <= 1'b0;
            leak_tmr_r <= 32'h0000_0000;
            leak_start_r <= 16'h0000;
            leak_rate_r <= 16'h0000;
            leak_err_r <= 1'b0;
        end
        else if (state_r == vec_pkg::VEC_SUCK &&
                 state_nxt == vec_pkg::VEC_HOLD)
        begin
            leak_run_r <= 1'b1;
            leak_tmr_r <= 32'h0000_0000;
            leak_start_r <= vacuum_level;
        end
        else if (leak_run_r && state_r != vec_pkg::VEC_HOLD)
            leak_run_r <= 1'b0;
        else if (leak_run_r && leak_tmr_r == SEC_CYCLES - 1)
        begin
            leak_run_r <= 1'b0;
            leak_rate_r <= (leak_start_r > vacuum_level) ?
                           leak_start_r - vacuum_level : 16'h0000;
            leak_err_r <= (leak_lim_r != 10'h000) &&
                          (leak_start_r > vacuum_level) &&
                          (leak_start_r - vacuum_level >
                           {6'h00, leak_lim_r});
        end
        else if (leak_run_r)
            leak_tmr_r <= leak_tmr_r + 32'h0000_0001;
        else if (leak_lim_r == 10'h000)
            leak_err_r <= 1'b0;
    end

    // R12 R21 conversion only for display
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vac_disp_r <= 32'h0000_0000;
        else
        begin
            case (vec_pkg::vec_unit_t'(unit_r))
                vec_pkg::VEC_U_INHG:
                    vac_disp_r <= ({16'h0, vacuum_level} *
                                   {16'h0, `VEC_INHG_MUL}) >> `VEC_SCALE_SH;
                vec_pkg::VEC_U_PSI:
                    vac_disp_r <= ({16'h0, vacuum_level} *
                                   {16'h0, `VEC_PSI_MUL}) >> `VEC_SCALE_SH;
                default: vac_disp_r <= {16'h0, vacuum_level};
            endcase
        end
    end

    // ****************************************
    // display blocks
    // ****************************************
    always_comb
    begin
        disp_block_nxt = 10'h000;
        disp_point_nxt = 3'h0;
        case (disp_item_r)
            // R17 counters highest block first
            3'h1:
            begin
                disp_block_nxt = blk3(cnt1_r, disp_idx_r);
                disp_point_nxt = 3'h4 >> disp_idx_r;
            end
            3'h2:
            begin
                disp_block_nxt = blk3(cnt2_r, disp_idx_r);
                disp_point_nxt = 3'h4 >> disp_idx_r;
            end
            // R18 part number, first point hidden
            3'h3:
            begin
                case (disp_idx_r)
                    2'h0: disp_block_nxt = PART_B0;
                    2'h1: disp_block_nxt = PART_B1;
                    2'h2: disp_block_nxt = PART_B2;
                    default: disp_block_nxt = PART_B3;
                endcase
                disp_point_nxt = (disp_idx_r == 2'h0) ? 3'h0 : 3'h4;
            end
            // R19 serial number in three blocks
            3'h4:
            begin
                disp_block_nxt = blk3(SERIAL_NO, disp_idx_r);
                disp_point_nxt = 3'h4 >> disp_idx_r;
            end
            // R20 software id until exit
            3'h5: disp_block_nxt = SW_ID;
            default: ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            disp_item_r <= 3'h0;
            disp_idx_r <= 2'h0;
            disp_block <= 10'h000;
            disp_point <= 3'h0;
        end
        else
        begin
            disp_block <= disp_block_nxt;
            disp_point <= disp_point_nxt;
            if (sel_wr)
            begin
                disp_item_r <= pwdata[2:0];
                disp_idx_r <= 2'h0;
            end
            else if (disp_next)
            begin
                if ((disp_item_r == 3'h3 && disp_idx_r == 2'h3) ||
                    (disp_item_r != 3'h3 && disp_idx_r == 2'h2) ||
                    disp_item_r == 3'h5)
                    disp_idx_r <= 2'h0;
                else
                    disp_idx_r <= disp_idx_r + 2'h1;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_blow_wins;
        blowoff_in |=> blowoff_valve && !suction_valve;
    endproperty
    a_blow_wins: assert property (p_blow_wins) // R07
        else $error("blow input did not win");

    property p_ext_blow;
        blowoff_in ##1 !blowoff_in && !suction_in && blow_time_r == 10'h000
            |=> !blowoff_valve;
    endproperty
    a_ext_blow: assert property (p_ext_blow) // R06
        else $error("external blow-off outlived its input");

    property p_halt;
        state_r == vec_pkg::VEC_SUCK && mode_r && suction_in &&
        !blowoff_in && vacuum_level >= switch_pt_r
            |=> state_r == vec_pkg::VEC_HOLD && !suction_valve;
    endproperty
    a_halt: assert property (p_halt) // R01
        else $error("suction not halted at switch point");

    property p_resume;
        state_r == vec_pkg::VEC_HOLD && suction_in && !blowoff_in &&
        vacuum_level < reset_pt_r |=> suction_valve;
    endproperty
    a_resume: assert property (p_resume) // R02
        else $error("suction not resumed below reset point");

    property p_no_ctrl;
        !mode_r && suction_in && !blowoff_in |=> suction_valve;
    endproperty
    a_no_ctrl: assert property (p_no_ctrl) // R04
        else $error("continuous suction dropped");

    property p_timed;
        (state_r == vec_pkg::VEC_SUCK || state_r == vec_pkg::VEC_HOLD) &&
        !suction_in && !blowoff_in
            |=> blowoff_valve == (blow_time_r != 10'h000);
    endproperty
    a_timed: assert property (p_timed) // R08
        else $error("timed blow-off choice wrong");

    property p_cnt1;
        suck_rise |=> cnt1_r == $past(cnt1_r) + 30'h1;
    endproperty
    a_cnt1: assert property (p_cnt1) // R14
        else $error("suction pulse not counted");

    property p_cnt2;
        !suction_valve ##1 suction_valve |-> cnt2_r == $past(cnt2_r) + 30'h1;
    endproperty
    a_cnt2: assert property (p_cnt2) // R15
        else $error("valve turn-on not counted");

    property p_nv;
        $changed(nv1_r) |-> mod1_r == 10'h000 && nv1_r == cnt1_r;
    endproperty
    a_nv: assert property (p_nv) // R16
        else $error("counter saved off the thousand step");

    property p_fact;
        fact_rst |=> switch_pt_r == `VEC_RST_SWITCH &&
                     cnt1_r >= $past(cnt1_r);
    endproperty
    a_fact: assert property (p_fact) // R13
        else $error("factory reset wrong");

    c_halt: cover property (state_r == vec_pkg::VEC_HOLD ##1
                            state_r == vec_pkg::VEC_SUCK);
    c_tblow: cover property (state_r == vec_pkg::VEC_TBLOW ##1
                             state_r == vec_pkg::VEC_IDLE);
    c_leak: cover property ($fell(leak_run_r) && leak_err_r);
endmodule

// [core/vec_defines.svh]
// register offsets, reset values and timing figures of the ejector control
// assumes a 200 MHz pclk and vacuum readings in whole mbar
`ifndef VEC_DEFINES_SVH
`define VEC_DEFINES_SVH

`define VEC_OFS_CTRL      12'h000
`define VEC_OFS_SWITCH    12'h004
`define VEC_OFS_RESET     12'h008
`define VEC_OFS_BLOW      12'h00C
`define VEC_OFS_LEAKLIM   12'h010
`define VEC_OFS_STATUS    12'h014
`define VEC_OFS_LEAKRATE  12'h018
`define VEC_OFS_VACDISP   12'h01C
`define VEC_OFS_CNT1      12'h020
`define VEC_OFS_CNT2      12'h024
`define VEC_OFS_NV1       12'h028
`define VEC_OFS_NV2       12'h02C
`define VEC_OFS_DISPSEL   12'h030
`define VEC_OFS_DISPOUT   12'h034

`define VEC_RST_MODE      1'h1
`define VEC_RST_UNIT      2'h0
`define VEC_RST_SWITCH    16'h02EE
`define VEC_RST_RESETPT   16'h0258
`define VEC_RST_BLOW      10'h000
`define VEC_RST_LEAK      10'h000
`define VEC_BLOW_MAX      10'h3E7
`define VEC_NV_WRAP       10'h3E7

`define VEC_CLK_NS        32'h0000_0005
`define VEC_HSEC_NS       32'h0098_9680
`define VEC_SEC_NS        32'h3B9A_CA00

`define VEC_INHG_MUL      16'h0BD0
`define VEC_PSI_MUL       16'h05CD
`define VEC_SCALE_SH      10
`endif

// [core/vec_pkg.sv]
// types shared by the ejector control
// assumes nothing beyond a SystemVerilog tool
package vec_pkg;
    typedef enum logic [4:0] {
        VEC_IDLE  = 5'h01,
        VEC_SUCK  = 5'h02,
        VEC_HOLD  = 5'h04,
        VEC_EBLOW = 5'h08,
        VEC_TBLOW = 5'h10
    } vec_state_t;
    typedef enum logic [1:0] {
        VEC_U_MBAR = 2'h0,
        VEC_U_KPA  = 2'h1,
        VEC_U_INHG = 2'h2,
        VEC_U_PSI  = 2'h3
    } vec_unit_t;
endpackage

// [test/vec_mach_model.sv]
// machine controller model driving suction and blow-off commands
// assumes the bench asks for commands on pclk
`timescale 1ns/1ps
module vec_mach_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic suck_cmd,
    input wire logic blow_cmd,
    output logic suction_in,
    output logic blowoff_in
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            suction_in <= 1'b0;
            blowoff_in <= 1'b0;
        end
        else
        begin
            suction_in <= suck_cmd;
            blowoff_in <= blow_cmd;
        end
    end
endmodule

// [test/tb_top.sv]
// self-checking bench of the ejector control
// assumes vec_ctrl and vec_mach_model are compiled first
`timescale 1ns/1ps
module tb_top;
logic pclk = 0, presetn = 0, psel = 0, penable = 0;
logic pwrite = 0, disp_next = 0, suck = 0, blow = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rd, sv;
logic pready, pslverr, er, suction_in, blowoff_in;
logic suction_valve, blowoff_valve;
logic [15:0] vac = 0;
logic [9:0] disp_block;
logic [2:0] disp_point;
int num_errors = 0, tests_run = 0;
always #2.5 pclk = ~pclk;
vec_mach_model u_vec_mach_model (.pclk(pclk), .presetn(presetn),
    .suck_cmd(suck), .blow_cmd(blow), .suction_in(suction_in),
    .blowoff_in(blowoff_in));
vec_ctrl #(.HSEC_CYCLES(4), .SEC_CYCLES(20)) u_vec_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .suction_in(suction_in), .blowoff_in(blowoff_in),
    .vacuum_level(vac), .disp_next(disp_next),
    .suction_valve(suction_valve), .blowoff_valve(blowoff_valve),
    .disp_block(disp_block), .disp_point(disp_point));
task summarize;
    if (num_errors == 0 && tests_run > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
task chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e)
    begin
        num_errors++;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
endtask
// request held until pready is seen high at a rising edge
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
        @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task drv(input logic s, b, input logic [15:0] v);
    @(posedge pclk);
    suck <= s;
    blow <= b;
    vac <= v;
endtask
task wv(input logic s, b, input int lim);
    int n;
    n = 0;
    @(negedge pclk);
    while ({suction_valve, blowoff_valve} !== {s, b} && n < lim)
    begin
        n++;
        @(negedge pclk);
    end
    chk({30'h0, suction_valve, blowoff_valve}, {30'h0, s, b});
endtask
task t_regs;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_0001);
    apb(0, 12'h004, 0);
    chk(rd, 32'h0000_02EE);
    apb(0, 12'h008, 0);
    chk(rd, 32'h0000_0258);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h0000_0000);
    apb(1, 12'h040, 32'h0000_1234);
    chk({31'h0, er}, 32'h0000_0001);
    apb(0, 12'h040, 0);
    chk(rd, 32'h0000_0000);
endtask
task t_hyst;
    apb(1, 12'h010, 32'h0000_0005);
    drv(1, 0, 16'h0000);
    wv(1, 0, 20);
    drv(1, 0, 16'h0320);
    wv(0, 0, 20);
    drv(1, 0, 16'h0316);
    repeat (30) @(posedge pclk);
    wv(0, 0, 0);
    apb(0, 12'h018, 0);
    chk(rd, 32'h0000_000A);
    apb(0, 12'h014, 0);
    chk(rd, 32'h0000_0090);
    drv(1, 0, 16'h01F4);
    wv(1, 0, 20);
    apb(0, 12'h020, 0);
    chk(rd, 32'h0000_0001);
    apb(0, 12'h024, 0);
    chk(rd, 32'h0000_0002);
endtask
task disp(input logic [31:0] sel, input logic [12:0] a, b, c);
    apb(1, 12'h030, sel);
    repeat (2) @(negedge pclk);
    chk({19'h0, disp_point, disp_block}, {19'h0, a});
    @(posedge pclk);
    disp_next <= 1;
    @(posedge pclk);
    disp_next <= 0;
    repeat (2) @(negedge pclk);
    chk({19'h0, disp_point, disp_block}, {19'h0, b});
    @(posedge pclk);
    disp_next <= 1;
    @(posedge pclk);
    disp_next <= 0;
    repeat (2) @(negedge pclk);
    chk({19'h0, disp_point, disp_block}, {19'h0, c});
endtask
task t_units;
    logic [31:0] e [4];
    e = '{32'h0000_01F4, 32'h0000_01F4, 32'h0000_05C4, 32'h0000_02D5};
    for (int u = 0; u < 4; u++)
    begin
        apb(1, 12'h000, {29'h0, u[1:0], 1'b1});
        apb(0, 12'h01C, 0);
        chk(rd, e[u]);
    end
    apb(0, 12'h004, 0);
    chk(rd, 32'h0000_02EE);
endtask
task t_blow;
    int n;
    apb(1, 12'h000, 32'h0000_0000);
    drv(1, 0, 16'h0384);
    repeat (20) @(posedge pclk);
    wv(1, 0, 0);
    apb(1, 12'h000, 32'h0000_0001);
    drv(1, 1, 16'h0000);
    wv(0, 1, 20);
    drv(0, 1, 16'h0000);
    repeat (10) @(posedge pclk);
    wv(0, 1, 0);
    drv(0, 0, 16'h0000);
    wv(0, 0, 20);
    apb(1, 12'h00C, 32'h0000_0002);
    drv(1, 0, 16'h0000);
    wv(1, 0, 20);
    drv(1, 1, 16'h0000);
    wv(0, 1, 20);
    drv(1, 0, 16'h0000);
    wv(1, 0, 20);
    drv(0, 0, 16'h0000);
    wv(0, 1, 20);
    n = 0;
    while (blowoff_valve === 1'b1 && n < 40)
    begin
        n++;
        @(negedge pclk);
    end
    chk({31'h0, n >= 6 && n <= 10}, 32'h0000_0001);
    apb(1, 12'h00C, 32'h0000_0000);
endtask
task t_fact;
    apb(0, 12'h020, 0);
    sv = rd;
    apb(1, 12'h004, 32'h0000_0384);
    apb(1, 12'h000, 32'h0000_0009);
    apb(0, 12'h004, 0);
    chk(rd, 32'h0000_02EE);
    apb(0, 12'h020, 0);
    chk(rd, sv);
    repeat (998)
    begin
        drv(1, 0, 16'h0000);
        drv(0, 0, 16'h0000);
    end
    apb(0, 12'h028, 0);
    chk(rd, 32'h0000_03E8);
    apb(0, 12'h02C, 0);
    chk(rd, 32'h0000_03E8);
endtask
initial
begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_hyst;
    disp(32'h0000_0001, {3'h4, 10'h000}, {3'h2, 10'h000},
        {3'h1, 10'h001});
    disp(32'h0000_0004, {3'h4, 10'h000}, {3'h2, 10'h07B},
        {3'h1, 10'h1C8});
    disp(32'h0000_0003, {3'h0, 10'h00C}, {3'h4, 10'h022},
        {3'h4, 10'h038});
    disp(32'h0000_0005, {3'h0, 10'h065}, {3'h0, 10'h065},
        {3'h0, 10'h065});
    t_units;
    t_blow;
    t_fact;
    summarize;
end
initial
begin
    #200000;
    num_errors++;
    summarize;
end
endmodule
